// *** crm_consts.vh ***
// Purpose: Shared timing and encoding constants for the compressor remote mode control.
// Assumes: 50 MHz system clock.
// Notes:   Times are kept in their printed unit and turned into cycle counts here.
`ifndef CRM_CONSTS_VH
`define CRM_CONSTS_VH

// Clock rate in kHz and the qualifying pulse time in milliseconds.
`define CRM_CLK_KHZ        50000
`define CRM_QUAL_MS        300
// Least time rounds up; 300 ms at 50 MHz is an exact count of 15,000,000 cycles.
`define CRM_QUAL_CYCLES    ((`CRM_QUAL_MS * `CRM_CLK_KHZ + 0) / 1)
// Width of the qualification counter.
`define CRM_CNT_W          24

// Mode encodings.
`define CRM_MODE_NONE      2'h0
`define CRM_MODE_MOMENTARY 2'h1
`define CRM_MODE_ALTERNATE 2'h2

// Number of cryocoolers.
`define CRM_NUM_COOLERS    3

`endif

// *** crm_qualify.v ***
// Purpose: Synchronise one command pin and report its level once it has held long enough.
// Assumes: The pin is asynchronous to clk.
// Notes:   The qualified level changes only after the raw level has been stable QUAL cycles.
`default_nettype none
`timescale 1ns/100ps
`include "crm_consts.vh"

module crm_qualify #(
  parameter [`CRM_CNT_W-1:0] QUAL = `CRM_QUAL_CYCLES
) (
  input  wire clk,
  input  wire nrst,
  input  wire pin,
  output wire level
);

  reg                  sync1_q;
  reg                  sync2_q;
  reg                  level_q;
  reg [`CRM_CNT_W-1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser; only the second stage is read by the filter.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Duration filter: a change shorter than QUAL cycles is treated as absent.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q   <= {`CRM_CNT_W{1'b0}};
      level_q <= 1'b0;
    end else if (sync2_q == level_q) begin
      cnt_q <= {`CRM_CNT_W{1'b0}};
    end else if (cnt_q >= QUAL - 1'b1) begin
      cnt_q   <= {`CRM_CNT_W{1'b0}};
      level_q <= sync2_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign level = level_q;

endmodule // crm_qualify
`default_nettype wire

// *** crm_top.v ***
// Purpose: Remote discrete-signal control of a cryopump compressor and its three cryocoolers.
// Assumes: Six isolated command pins arrive asynchronously; five contact outputs close when high.
// Notes:   Mode is chosen once after reset and kept until the next power-on reset.
`default_nettype none
`timescale 1ns/100ps
`include "crm_consts.vh"

module crm_top #(
  parameter [`CRM_CNT_W-1:0] QUAL = `CRM_QUAL_CYCLES
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire       pump_start_cmd,
  input  wire       pump_stop_cmd,
  input  wire       pump_onoff_cmd,
  input  wire       cooler1_command,
  input  wire       cooler2_command,
  input  wire       cooler3_command,
  input  wire       fault,
  output wire       pump_answerback_contact,
  output wire       alarm_contact,
  output wire       cooler1_answerback,
  output wire       cooler2_answerback,
  output wire       cooler3_answerback,
  output wire [1:0] mode
);

  wire [5:0] raw_w;
  wire [5:0] qual_w;
  wire       fault_w;
  reg  [1:0] mode_q;
  reg  [1:0] mode_d;
  reg        pump_q;
  reg        pump_d;
  reg  [2:0] cool_q;
  reg  [2:0] cool_d;
  reg        alarm_q;
  reg        start_seen_q;

  // Pin order: start, stop, on/off, cooler 1..3.
  assign raw_w = {cooler3_command, cooler2_command, cooler1_command,
                  pump_onoff_cmd, pump_stop_cmd, pump_start_cmd};

  ////////////////////////////////////////////////////////////////////////////////
  // One qualifier per command pin; the fault pin uses a short filter of its own.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_q
      crm_qualify #(.QUAL(QUAL)) u_q (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (raw_w[gi]),
        .level (qual_w[gi])
      );
    end
  endgenerate

  crm_qualify #(.QUAL({{(`CRM_CNT_W-1){1'b0}}, 1'b1})) u_fault (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (fault),
    .level (fault_w)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Mode choice: decided once by the first qualified start or on/off command (start wins), never changed.
  // The stop line is held high in momentary mode, so it cannot pick a mode by itself.
  always @* begin
    mode_d = mode_q;
    if (mode_q == `CRM_MODE_NONE) begin
      if (qual_w[0])
        mode_d = `CRM_MODE_MOMENTARY;
      else if (qual_w[2])
        mode_d = `CRM_MODE_ALTERNATE;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      mode_q <= `CRM_MODE_NONE;
    else
      mode_q <= mode_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pump state. Stop wins over start in momentary mode, so a released stop line
  // cannot be overridden by a start held at the same time. Lines of the unused
  // mode are ignored, which keeps a stray wire from disturbing the pump.
  always @* begin
    pump_d = pump_q;
    case (mode_d)
      `CRM_MODE_MOMENTARY: begin
        if (!qual_w[1])
          pump_d = 1'b0;
        else if (qual_w[0] && !start_seen_q)
          pump_d = 1'b1;
      end
      `CRM_MODE_ALTERNATE: begin
        pump_d = qual_w[2];
      end
      default: begin
        pump_d = 1'b0;
      end
    endcase
    if (alarm_q)
      pump_d = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Coolers follow their own commands only while the pump is running.
  always @* begin
    cool_d = qual_w[5:3] & {`CRM_NUM_COOLERS{pump_d}};
    if (!pump_d)
      cool_d = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output state. Start tracking clears while the pump is off, so a start held through a stop restarts the pump once stop is high again.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pump_q       <= 1'b0;
      cool_q       <= 3'h0;
      alarm_q      <= 1'b0;
      start_seen_q <= 1'b0;
    end else begin
      pump_q       <= pump_d;
      cool_q       <= cool_d;
      alarm_q      <= fault_w;
      start_seen_q <= qual_w[0] & pump_d;
    end
  end

  // Five contact outputs, all from flip-flops.
  assign pump_answerback_contact = pump_q;
  assign alarm_contact           = alarm_q;
  assign cooler1_answerback      = cool_q[0];
  assign cooler2_answerback      = cool_q[1];
  assign cooler3_answerback      = cool_q[2];
  assign mode                    = mode_q;

endmodule // crm_top
`default_nettype wire

// *** crm_props.sv ***
// Purpose: Mode and timing checks at the compressor remote control ports.
// Assumes: QUAL is handed on by the bind.
// Notes:   Run-length counters measure how long each cause has held at the pins.
`timescale 1ns/100ps
`default_nettype none
module crm_props #(
  parameter int QUAL = 8
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       pump_start_cmd,
  input wire logic       pump_stop_cmd,
  input wire logic       pump_onoff_cmd,
  input wire logic       cooler1_command,
  input wire logic       cooler2_command,
  input wire logic       cooler3_command,
  input wire logic       fault,
  input wire logic       pump_answerback_contact,
  input wire logic       alarm_contact,
  input wire logic       cooler1_answerback,
  input wire logic       cooler2_answerback,
  input wire logic       cooler3_answerback,
  input wire logic [1:0] mode
);
  int hi_q, pk_q, lo_q, on_q, c1_q;
  // Counters saturate so that a long hold never wraps back into a short one.
  function automatic int step(input int v, input logic c);
    return c ? ((v < 999) ? v + 1 : v) : 0;
  endfunction
  // The peak start hold is kept so a mode pick can be traced to its pulse.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hi_q <= 0;
      pk_q <= 0;
      lo_q <= 0;
      on_q <= 0;
      c1_q <= 0;
    end else begin
      hi_q <= step(hi_q, pump_start_cmd);
      pk_q <= (hi_q > pk_q) ? hi_q : pk_q;
      lo_q <= step(lo_q, (mode == 2'h1 && !pump_stop_cmd) || (mode == 2'h2 && !pump_onoff_cmd));
      on_q <= step(on_q, mode == 2'h2 && pump_onoff_cmd && !fault && !alarm_contact);
      c1_q <= step(c1_q, pump_answerback_contact && cooler1_command && !fault);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_mode_stays_fixed: assert property (mode != 2'h0 |=> $stable(mode)) else $error("mode changed");
  a_mode_code_legal: assert property (mode != 2'h3) else $error("mode code illegal");
  a_start_needs_hold: assert property ($rose(mode == 2'h1) |-> pk_q >= QUAL - 1) else $error("short start");
  a_cooler_needs_pump: assert property ((cooler1_answerback || cooler2_answerback || cooler3_answerback)
    |-> pump_answerback_contact) else $error("cooler without pump");
  a_stop_drops_pump: assert property (lo_q > QUAL + 4 |-> !pump_answerback_contact && !cooler1_answerback)
    else $error("pump kept after stop");
  a_run_follows_onoff: assert property (on_q > QUAL + 4 |-> pump_answerback_contact) else $error("pump late");
  a_cooler_follows_cmd: assert property (c1_q > QUAL + 4 && pump_answerback_contact |-> cooler1_answerback)
    else $error("cooler late");
  a_alarm_follows_fault: assert property (fault [*5] |=> alarm_contact) else $error("alarm late");
  a_pump_needs_mode: assert property (pump_answerback_contact |-> mode != 2'h0) else $error("pump without mode");
endmodule // crm_props
bind crm_top crm_props #(.QUAL(QUAL)) u_props (.*);
`default_nettype wire

// *** crm_equip_model.sv ***
// Purpose: Equipment-side sequence controller driving the six command lines.
// Assumes: Lines change just after a falling clock edge.
// Notes:   Only the lines of the mode under test are ever raised.
`timescale 1ns/100ps
`default_nettype none
module crm_equip_model (
  input  wire logic       clk,
  output var  logic [5:0] lines
);
  // Lines are start, stop, on/off, cooler 1, 2, 3 from the top; all open at power-up.
  initial lines = 6'h00;
  // Holding past the filter time is what makes a command valid, so the hold is explicit.
  task automatic drive(input logic [5:0] v, input int hold);
    @(negedge clk);
    lines = v;
    repeat (hold) @(negedge clk);
  endtask
endmodule // crm_equip_model
`default_nettype wire

// *** test_crm_top.sv ***
// Purpose: Self-checking bench for the compressor remote control.
// Assumes: Short filter time QUAL in simulation.
// Notes:   Each mode needs its own power-on reset because the pick is kept.
`timescale 1ns/100ps
`default_nettype none
module test_crm_top;
  localparam int QUAL = 8;
  localparam int LAT  = QUAL + 6;
  logic       clk      = 1'b0;
  logic       nrst     = 1'b0;
  logic       fault    = 1'b0;
  int         failures = 0;
  int         compares = 0;
  wire  [5:0] lines;
  wire        pump, alarm, c1, c2, c3;
  wire  [1:0] mode;
  wire  [6:0] seen;
  assign seen = {mode, pump, alarm, c1, c2, c3};
  // A 50 MHz clock.
  always #10 clk = ~clk;
  crm_equip_model eq_u (.clk(clk), .lines(lines));
  crm_top #(.QUAL(24'(QUAL))) dut_u (.clk(clk), .nrst(nrst), .pump_start_cmd(lines[5]), .pump_stop_cmd(lines[4]),
    .pump_onoff_cmd(lines[3]), .cooler1_command(lines[2]), .cooler2_command(lines[1]), .cooler3_command(lines[0]),
    .fault(fault), .pump_answerback_contact(pump), .alarm_contact(alarm), .cooler1_answerback(c1),
    .cooler2_answerback(c2), .cooler3_answerback(c3), .mode(mode));
  // Status is mode, pump, alarm, cooler 1, 2, 3; checked once the slowest answer has landed.
  task automatic look(input string what, input logic [6:0] exp);
    repeat (LAT) @(negedge clk);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic restart();
    eq_u.drive(6'h00, 0);
    nrst = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
  endtask
  task automatic t_momentary();
    restart();
    eq_u.drive(6'h10, QUAL + 4);
    eq_u.drive(6'h30, QUAL - 3);
    eq_u.drive(6'h10, 0);
    look("short start", 7'h00);
    eq_u.drive(6'h30, QUAL + 4);
    eq_u.drive(6'h10, 0);
    look("start latch", 7'h30);
    for (int i = 0; i < 3; i++) begin
      eq_u.drive(6'h10 | (6'h04 >> i), 0);
      look("cooler on", 7'h30 | (7'h04 >> i));
    end
    eq_u.drive(6'h01, 0);
    look("stop", 7'h20);
    eq_u.drive(6'h11, 0);
    look("stop latched", 7'h20);
  endtask
  task automatic t_alternate();
    restart();
    eq_u.drive(6'h04, 0);
    look("cooler idle", 7'h00);
    eq_u.drive(6'h0c, 0);
    look("onoff run", 7'h54);
    eq_u.drive(6'h04, 0);
    look("onoff stop", 7'h40);
    fault = 1'b1;
    look("alarm", 7'h48);
    fault = 1'b0;
  endtask
  task automatic report_and_stop();
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    t_momentary();
    t_alternate();
    report_and_stop();
  end
  // Both scenarios together need about 220 cycles, so this limit only trips on a hang.
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule // test_crm_top
`default_nettype wire
